// File: src/pacc_core.sv
/*
 * Pager address code converter: user address and code type in, address
 * codewords, phase, base frame and error out, plus an LSB-first
 * serialiser and a codeword range classifier.
 * Assumes the requesting logic runs on the same clock as this block.
 */
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// R1: address words are 21 bits wide
// R2: address range selects the conversion formula
// R3: short word is address plus 8000 hex
// R4: long address gives lower then upper word
// R5: long 1-x lower is 1 plus remainder
// R6: set 1-2 upper counts down from 1FFFFF
// R7: sets 1-3, 1-4 upper from 1D8000 up
// R8: set 2-3 words from 1F7FFF and 1C8000
// R9: lowest set 1-2 address gives 1FFFFE
// R10: words leave least significant bit first
// R11: short and long 1-x address ranges classified
// R12: long 2-3 address range classified
// R13: zero, gaps and reserved ranges flagged
// R14: sets 2-4 and 3-4 never produced
// R15: words 000000 and 1FFFFF are idle
// R16: codewords classified by value range
// R17: phase is address minus offset, div 4 mod 4
// R18: frame is address minus offset, div 16 mod 128
// R19: phase numbers 0..3 mean phases A..D
// R20: offsets 0..3 within each four types
// R21: U..X fixed phase, Y any, Z all
// R22: host gives frame 0..127 and collapse 0..5
// R23: all-phase code types rejected
// R24: collapse b means every 2^b frames
// R25: results and done one cycle after valid
// R26: error flag set and words suppressed
module pacc_core
   import pacc_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              req_valid,
   input  wire logic [32:0]       req_addr,
   input  wire logic [4:0]        req_type,
   input  wire logic [6:0]        req_frame,
   input  wire logic [2:0]        req_collapse,
   input  wire logic [20:0]       cw_in,
   output logic                   done,
   output logic                   err,
   output logic                   is_long,
   output logic [20:0]            word_lo,
   output logic [20:0]            word_hi,
   output logic [1:0]             phase,
   output logic                   any_phase,
   output logic [6:0]             frame,
   output logic [2:0]             collapse,
   output logic [7:0]             frame_step,
   output pacc_cw_class_t         cw_class,
   output logic                   ser_valid,
   output logic                   ser_bit,
   output logic                   ser_last
);
   // ------------------------------------------------------------------
   // range decode and arithmetic
   // ------------------------------------------------------------------
   pacc_addr_class_t ac;
   logic [32:0]      d1;
   logic [32:0]      d2;
   logic [32:0]      a_off;
   logic [20:0]      lo1;
   logic [20:0]      up12;
   logic [20:0]      up13;
   logic [20:0]      lo23;
   logic [20:0]      up23;
   logic [20:0]      wshort;
   logic             std_type;
   logic             xpl_type;
   logic             all_type;
   logic             type_bad;

   always_comb begin
      // special short ranges convert like ordinary short ones
      if (req_addr == 33'h0_0000_0000)  ac = PACC_AC_ILLEGAL; // [R13]
      else if (req_addr <= SHORT_HI)    ac = PACC_AC_SHORT; // [R11]
      else if (req_addr <= RSV1_HI)     ac = PACC_AC_ILLEGAL; // [R13]
      else if (req_addr <= SPEC_HI)     ac = PACC_AC_SHORT;
      else if (req_addr <= ILL2_HI)     ac = PACC_AC_ILLEGAL; // [R13]
      else if (req_addr <= L12_HI)      ac = PACC_AC_L12; // [R11]
      else if (req_addr <= L13_HI)      ac = PACC_AC_L13; // [R11]
      else if (req_addr <= L14_HI)      ac = PACC_AC_L14; // [R11]
      else if (req_addr <= L23_CTRY_HI) ac = PACC_AC_L23; // [R12]
      else if (req_addr <= L23_RSV_HI)  ac = PACC_AC_ILLEGAL; // [R13]
      else if (req_addr <= L23_HI)      ac = PACC_AC_L23; // [R12]
      else                              ac = PACC_AC_ILLEGAL; // [R13] [R14]
   end

   assign d1     = req_addr - LONG1_BASE;
   assign d2     = req_addr - LONG23_BASE;
   assign wshort = req_addr[20:0] + SHORT_OFS; // [R3]
   assign lo1    = {6'h00, d1[14:0]} + WORD_ONE; // [R5]
   assign up12   = UP12_BASE - {3'h0, d1[32:15]}; // [R6] [R9]
   assign up13   = UP13_BASE + {3'h0, d1[32:15]}; // [R7]
   assign lo23   = LO23_BASE + {6'h00, d2[14:0]}; // [R8]
   assign up23   = UP23_BASE + {3'h0, d2[32:15]}; // [R8]

   assign std_type = (req_type < TYPE_U);
   assign xpl_type = (req_type >= TYPE_U) && (req_type <= TYPE_Z);
   assign all_type = ((req_type >= TYPE_I) && (req_type < TYPE_U))
                     || (req_type == TYPE_Z); // [R21]
   assign type_bad = !(std_type || xpl_type) || all_type // [R23]
                     || (xpl_type && (req_collapse > COLLAPSE_MAX)); // [R22]
   // offset is the low two bits of the type within each group of four
   assign a_off    = req_addr - {31'h0, req_type[1:0]}; // [R20]

   // ------------------------------------------------------------------
   // result registers
   // ------------------------------------------------------------------
   logic        done_reg, done_next;
   logic        err_reg, err_next;
   logic        long_reg, long_next;
   logic [20:0] lo_reg, lo_next; // [R1]
   logic [20:0] hi_reg, hi_next;
   logic [1:0]  ph_reg, ph_next;
   logic        anyp_reg, anyp_next;
   logic [6:0]  fr_reg, fr_next;
   logic [2:0]  col_reg, col_next;
   logic [7:0]  step_reg, step_next;
   pacc_cw_class_t cwc_reg, cwc_next;

   always_comb begin
      done_next = req_valid; // [R25]
      err_next  = err_reg;
      long_next = long_reg;
      lo_next   = lo_reg;
      hi_next   = hi_reg;
      ph_next   = ph_reg;
      anyp_next = anyp_reg;
      fr_next   = fr_reg;
      col_next  = col_reg;
      step_next = step_reg;
      if (req_valid) begin
         err_next  = (ac == PACC_AC_ILLEGAL) || type_bad; // [R26]
         long_next = 1'b0;
         lo_next   = 21'h00_0000;
         hi_next   = 21'h00_0000;
         case (ac) // [R2]
            PACC_AC_SHORT: lo_next = wshort; // [R3]
            PACC_AC_L12: begin // [R4]
               long_next = 1'b1;
               lo_next   = lo1;
               hi_next   = up12;
            end
            PACC_AC_L13, PACC_AC_L14: begin
               long_next = 1'b1;
               lo_next   = lo1;
               hi_next   = up13;
            end
            PACC_AC_L23: begin
               long_next = 1'b1;
               lo_next   = lo23;
               hi_next   = up23;
            end
            default: long_next = 1'b0;
         endcase
         if (err_next) begin // [R26]
            long_next = 1'b0;
            lo_next   = 21'h00_0000;
            hi_next   = 21'h00_0000;
         end
         col_next  = req_collapse;
         step_next = 8'h01 << req_collapse; // [R24]
         if (std_type) begin
            ph_next   = a_off[3:2]; // [R17] [R19]
            fr_next   = a_off[10:4]; // [R18]
            anyp_next = (req_type >= 5'h04);
         end else begin
            // explicit types carry the frame from the host
            ph_next   = 2'(req_type - TYPE_U); // [R21]
            fr_next   = req_frame; // [R22]
            anyp_next = (req_type >= TYPE_Y);
         end
      end
   end

   // codeword classifier runs every cycle on its own input
   always_comb begin
      if (cw_in == CW_IDLE0 || cw_in == CW_IDLE1) cwc_next = PACC_CW_IDLE; // [R15]
      else if (cw_in <= CW_L1_HI)                cwc_next = PACC_CW_LONG1; // [R16]
      else if (cw_in <= CW_S_HI)                 cwc_next = PACC_CW_SHORT;
      else if (cw_in <= CW_L3_HI)                cwc_next = PACC_CW_LONG3;
      else if (cw_in <= CW_L4_HI)                cwc_next = PACC_CW_LONG4;
      else if (cw_in <= CW_SS_HI)                cwc_next = PACC_CW_SPECIAL;
      else                                       cwc_next = PACC_CW_LONG2;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         done_reg <= 1'b0;
         err_reg  <= 1'b0;
         long_reg <= 1'b0;
         lo_reg   <= 21'h00_0000;
         hi_reg   <= 21'h00_0000;
         ph_reg   <= 2'h0;
         anyp_reg <= 1'b0;
         fr_reg   <= 7'h00;
         col_reg  <= 3'h0;
         step_reg <= 8'h01;
         cwc_reg  <= PACC_CW_IDLE;
      end else begin
         done_reg <= done_next;
         err_reg  <= err_next;
         long_reg <= long_next;
         lo_reg   <= lo_next;
         hi_reg   <= hi_next;
         ph_reg   <= ph_next;
         anyp_reg <= anyp_next;
         fr_reg   <= fr_next;
         col_reg  <= col_next;
         step_reg <= step_next;
         cwc_reg  <= cwc_next;
      end
   end

   // ------------------------------------------------------------------
   // LSB-first serialiser
   // ------------------------------------------------------------------
   // a new good result is ignored while a stream is running; only the idle state loads one
   pacc_ser_state_t st_reg, st_next;
   logic [41:0]     sh_reg, sh_next;
   logic [5:0]      cnt_reg, cnt_next;
   logic            sv_reg, sv_next;
   logic            sb_reg, sb_next;
   logic            sl_reg, sl_next;

   always_comb begin
      st_next  = st_reg;
      sh_next  = sh_reg;
      cnt_next = cnt_reg;
      sv_next  = 1'b0;
      sb_next  = sb_reg;
      sl_next  = 1'b0;
      case (st_reg)
         PACC_SER_IDLE: begin
            if (done_reg && !err_reg) begin
               sh_next  = {hi_reg, lo_reg}; // [R4]
               cnt_next = long_reg ? 6'h29 : 6'h14;
               st_next  = PACC_SER_SHIFT;
            end
         end
         PACC_SER_SHIFT: begin
            sv_next  = 1'b1;
            sb_next  = sh_reg[0]; // [R10]
            sh_next  = {1'b0, sh_reg[41:1]};
            sl_next  = (cnt_reg == 6'h00);
            cnt_next = cnt_reg - 6'h01;
            if (cnt_reg == 6'h00) st_next = PACC_SER_IDLE;
         end
         default: st_next = PACC_SER_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_reg  <= PACC_SER_IDLE;
         sh_reg  <= 42'h000_0000_0000;
         cnt_reg <= 6'h00;
         sv_reg  <= 1'b0;
         sb_reg  <= 1'b0;
         sl_reg  <= 1'b0;
      end else begin
         st_reg  <= st_next;
         sh_reg  <= sh_next;
         cnt_reg <= cnt_next;
         sv_reg  <= sv_next;
         sb_reg  <= sb_next;
         sl_reg  <= sl_next;
      end
   end

   assign done = done_reg;
   assign err = err_reg;
   assign is_long = long_reg;
   assign word_lo = lo_reg;
   assign word_hi = hi_reg;
   assign phase = ph_reg;
   assign any_phase = anyp_reg;
   assign frame = fr_reg;
   assign collapse = col_reg;
   assign frame_step = step_reg;
   assign cw_class = cwc_reg;
   assign ser_valid = sv_reg;
   assign ser_bit = sb_reg;
   assign ser_last = sl_reg;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   AST_DONE_LATENCY: assert property (req_valid |=> done) // [R25]
      else $error("done not one cycle after valid");
   AST_ERR_SUPPRESS: assert property (done && err |-> // [R26]
      (word_lo == 21'h00_0000 && word_hi == 21'h00_0000 && !is_long))
      else $error("words not suppressed on error");
   AST_SHORT_WORD: assert property (req_valid && req_addr != 33'h0 // [R3]
      && req_addr <= SHORT_HI && !type_bad |=>
      word_lo == $past(req_addr[20:0]) + SHORT_OFS && !is_long)
      else $error("short word wrong");
   AST_L12_LOWEST: assert property (req_valid && !type_bad // [R9]
      && req_addr == ILL2_HI + 33'd1 |=>
      word_hi == 21'h1F_FFFE && word_lo == WORD_ONE)
      else $error("lowest long 1-2 address wrong");
   AST_ZERO_ILLEGAL: assert property (req_valid // [R13]
      && req_addr == 33'h0 |=> err)
      else $error("address zero not flagged");
   AST_ALLPHASE: assert property (req_valid && req_type == TYPE_Z // [R23]
      |=> err)
      else $error("all-phase type accepted");
   AST_PHASE_STD: assert property (req_valid && req_type < TYPE_U // [R17]
      |=> phase == 2'($past(req_addr - req_type[1:0]) >> 2)
      && frame == 7'($past(req_addr - req_type[1:0]) >> 4)) // [R18]
      else $error("standard phase or frame wrong");
   AST_IDLE_CW: assert property (cw_in == CW_IDLE1 // [R15]
      |=> cw_class == PACC_CW_IDLE)
      else $error("idle codeword misclassified");
   AST_SER_FIRST: assert property (done && !err && st_reg == PACC_SER_IDLE
      |=> ##1 ser_valid && ser_bit == $past(word_lo[0], 2)) // [R10]
      else $error("serial stream not lsb first");
   AST_LONG_SET: assert property (req_valid && !type_bad
      && req_addr > L13_HI && req_addr <= L14_HI |=> // [R7]
      is_long && word_hi >= UP13_BASE)
      else $error("long 1-4 upper word wrong");
   COV_SHORT: cover property (done && !err && !is_long);
   COV_LONG: cover property (done && !err && is_long);
   COV_ERR: cover property (done && err);
   COV_SER_END: cover property (ser_last);

endmodule // pacc_core

`default_nettype wire

// File: src/pacc_pkg.sv
/*
 * Constants and types for the pager address code converter.
 * Assumes a single clock domain; the package is imported whole by the core.
 */
package pacc_pkg;
   // ------------------------------------------------------------------
   // user address ranges (decimal, inclusive upper bounds)
   // ------------------------------------------------------------------
   localparam int unsigned ADDR_W = 33;
   localparam logic [32:0] SHORT_HI    = 33'd1933312;
   localparam logic [32:0] ILL1_HI     = 33'd1998848;
   localparam logic [32:0] RSV1_HI     = 33'd2009087;
   localparam logic [32:0] SPEC_HI     = 33'd2029599;
   localparam logic [32:0] RSV2_HI     = 33'd2031614;
   localparam logic [32:0] ILL2_HI     = 33'd2101248;
   localparam logic [32:0] L12_HI      = 33'd1075843072;
   localparam logic [32:0] L13_HI      = 33'd2149584896;
   localparam logic [32:0] L14_HI      = 33'd3223326720;
   localparam logic [32:0] L23_CTRY_HI = 33'd3923326750;
   localparam logic [32:0] L23_RSV_HI  = 33'd4280000000;
   localparam logic [32:0] L23_HI      = 33'd4291000000;
   // ------------------------------------------------------------------
   // codeword arithmetic
   // ------------------------------------------------------------------
   localparam int unsigned WORD_W = 21;
   localparam int unsigned MOD_W  = 15;
   localparam logic [32:0] LONG1_BASE = 33'h0_001F_9001;
   localparam logic [32:0] LONG23_BASE = 33'h0_001F_8FFF;
   localparam logic [20:0] SHORT_OFS  = 21'h00_8000;
   localparam logic [20:0] WORD_ONE   = 21'h00_0001;
   localparam logic [20:0] UP12_BASE  = 21'h1F_FFFF;
   localparam logic [20:0] UP13_BASE  = 21'h1D_8000;
   localparam logic [20:0] LO23_BASE  = 21'h1F_7FFF;
   localparam logic [20:0] UP23_BASE  = 21'h1C_8000;
   // ------------------------------------------------------------------
   // codeword classification bounds (inclusive upper)
   // ------------------------------------------------------------------
   localparam logic [20:0] CW_IDLE0  = 21'h00_0000;
   localparam logic [20:0] CW_L1_HI  = 21'h00_8000;
   localparam logic [20:0] CW_S_HI   = 21'h1E_0000;
   localparam logic [20:0] CW_L3_HI  = 21'h1E_8000;
   localparam logic [20:0] CW_L4_HI  = 21'h1F_0000;
   localparam logic [20:0] CW_SS_HI  = 21'h1F_7FFE;
   localparam logic [20:0] CW_IDLE1  = 21'h1F_FFFF;
   // ------------------------------------------------------------------
   // code types: 0..11 standard rule (A..L), 12..17 explicit (U..Z)
   // ------------------------------------------------------------------
   localparam logic [4:0] TYPE_A = 5'h00;
   localparam logic [4:0] TYPE_I = 5'h08;
   localparam logic [4:0] TYPE_U = 5'h0C;
   localparam logic [4:0] TYPE_Y = 5'h10;
   localparam logic [4:0] TYPE_Z = 5'h11;
   localparam logic [2:0] COLLAPSE_MAX = 3'h5;

   typedef enum logic [2:0] {
      PACC_CW_IDLE, PACC_CW_LONG1, PACC_CW_SHORT, PACC_CW_LONG3,
      PACC_CW_LONG4, PACC_CW_SPECIAL, PACC_CW_LONG2
   } pacc_cw_class_t;

   typedef enum logic [2:0] {
      PACC_AC_ILLEGAL, PACC_AC_SHORT, PACC_AC_L12, PACC_AC_L13,
      PACC_AC_L14, PACC_AC_L23
   } pacc_addr_class_t;

   typedef enum logic { PACC_SER_IDLE, PACC_SER_SHIFT } pacc_ser_state_t;
endpackage

// File: testbench/pacc_host.sv
/*
 * Host-side model for the pager address code converter: presents one
 * request per clock and holds every field until the next call.
 * Assumes the bench calls put just after a rising clock edge.
 */
`timescale 1ns/1ns
`default_nettype none

module pacc_host
   import pacc_pkg::*;
(
   output var logic        req_valid,
   output var logic [32:0] req_addr,
   output var logic [4:0]  req_type,
   output var logic [6:0]  req_frame,
   output var logic [2:0]  req_collapse
);
   initial begin
      req_valid    = 1'b0;
      req_addr     = 33'h0_0000_0000;
      req_type     = 5'h00;
      req_frame    = 7'h00;
      req_collapse = 3'h0;
   end

   // ------------------------------------------------------------------
   // request driver
   // ------------------------------------------------------------------
   // strobe and fields change together, once a cycle
   task automatic put(input logic v, input logic [32:0] a,
                      input logic [4:0] t, input logic [6:0] f,
                      input logic [2:0] c);
      req_valid    = v;
      req_addr     = a;
      req_type     = t;
      req_frame    = f;  // 7 bits hold the frame inside 0..127
      // collapse above 5 is refused only with explicit code types (12..17)
      req_collapse = c;
   endtask
endmodule // pacc_host

`default_nettype wire

// File: testbench/pager_address_code_converter_test.sv
/*
 * Self-checking bench for the pager address code converter: boundary
 * sweeps over every code type, seeded random traffic, serial streams.
 * Assumes the core answers one cycle after each request.
 */
`timescale 1ns/1ns
`default_nettype none

module pager_address_code_converter_test
   import pacc_pkg::*;
;
   typedef struct packed {
      logic        err;
      logic        lng;
      logic [20:0] lo;
      logic [20:0] hi;
      logic [1:0]  ph;
      logic        anyp;
      logic [6:0]  fr;
      logic        chk;
   } pacc_exp_t;

   logic           clock;
   logic           rst_n;
   logic           req_valid;
   logic [32:0]    req_addr;
   logic [4:0]     req_type;
   logic [6:0]     req_frame;
   logic [2:0]     req_collapse;
   logic [20:0]    cw_in;
   logic           done, err, is_long, any_phase, ser_valid, ser_bit;
   logic           ser_last;
   logic [20:0]    word_lo, word_hi;
   logic [1:0]     phase;
   logic [6:0]     frame;
   logic [2:0]     collapse;
   logic [7:0]     frame_step;
   pacc_cw_class_t cw_class;
   int             err_total, check_count, cyc, done_cyc, first_cyc;
   int             last_idx;
   logic           pend_v, have_last;
   logic [2:0]     pend_c;
   logic [20:0]    cw_q;
   pacc_exp_t      pe, last_e;
   logic           sq[$];
   logic [32:0]    bnd[26];
   logic [20:0]    cwb[14];

   pacc_host host (.req_valid(req_valid), .req_addr(req_addr),
      .req_type(req_type), .req_frame(req_frame),
      .req_collapse(req_collapse));

   pacc_core dut (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
      .req_addr(req_addr), .req_type(req_type), .req_frame(req_frame),
      .req_collapse(req_collapse), .cw_in(cw_in), .done(done),
      .err(err), .is_long(is_long), .word_lo(word_lo),
      .word_hi(word_hi), .phase(phase), .any_phase(any_phase),
      .frame(frame), .collapse(collapse), .frame_step(frame_step),
      .cw_class(cw_class), .ser_valid(ser_valid), .ser_bit(ser_bit),
      .ser_last(ser_last));

   initial clock = 1'b0;
   always #4 clock = ~clock;

   // ------------------------------------------------------------------
   // reference models
   // ------------------------------------------------------------------
   function automatic pacc_exp_t ref_conv(logic [32:0] a, logic [4:0] t,
                                          logic [6:0] f, logic [2:0] c);
      pacc_exp_t e;
      longint    d;
      longint    off;
      e = '0;
      off = t % 4;
      e.err = a == 0 || (a > SHORT_HI && a <= RSV1_HI) ||
              (a > SPEC_HI && a <= ILL2_HI) || a > L23_HI ||
              (a > L23_CTRY_HI && a <= L23_RSV_HI);
      e.err = e.err || t > 17 || (t >= 8 && t <= 11) || t == 17 ||
              (t >= 12 && c > 5);
      e.chk = a >= off || t >= 12;
      if (t < 12) begin
         e.ph   = 2'((a - off) >> 2);
         e.fr   = 7'((a - off) >> 4);
         e.anyp = t >= 4;
      end else begin
         e.ph   = 2'(t - 12);
         e.fr   = f;
         e.anyp = t == 16;
      end
      if (e.err) return e;
      if (a <= SPEC_HI) begin
         e.lo = 21'(a + SHORT_OFS);
      end else if (a <= L14_HI) begin
         e.lng = 1'b1;
         d = a - LONG1_BASE;
         e.lo = 21'(WORD_ONE + d % 32768);
         if (a <= L12_HI) e.hi = 21'(UP12_BASE - d / 32768);
         else e.hi = 21'(UP13_BASE + d / 32768);
      end else begin
         e.lng = 1'b1;
         d = a - LONG23_BASE;
         e.lo = 21'(LO23_BASE + d % 32768);
         e.hi = 21'(UP23_BASE + d / 32768);
      end
      return e;
   endfunction

   function automatic pacc_cw_class_t cw_exp(logic [20:0] w);
      if (w == CW_IDLE0 || w == CW_IDLE1) return PACC_CW_IDLE;
      if (w <= CW_L1_HI) return PACC_CW_LONG1;
      if (w <= CW_S_HI) return PACC_CW_SHORT;
      if (w <= CW_L3_HI) return PACC_CW_LONG3;
      if (w <= CW_L4_HI) return PACC_CW_LONG4;
      if (w <= CW_SS_HI) return PACC_CW_SPECIAL;
      return PACC_CW_LONG2;
   endfunction

   // ------------------------------------------------------------------
   // checking and stepping
   // ------------------------------------------------------------------
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (err_total == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // check what the previous edge produced, then drive the next cycle
   task automatic step(input logic v, input logic [32:0] a,
                       input logic [4:0] t, input logic [6:0] f,
                       input logic [2:0] c, input logic [20:0] w);
      @(posedge clock);
      #1;
      cyc++;
      check(cw_class, cw_exp(cw_q));
      check(done, pend_v);
      if (pend_v) begin
         check({err, word_lo, word_hi}, {pe.err, pe.lo, pe.hi});
         if (!pe.err) begin
            check(is_long, pe.lng);
            check({collapse, frame_step}, {pend_c, 8'h01 << pend_c});
            if (pe.chk) check({frame, any_phase}, {pe.fr, pe.anyp});
            if (pe.chk && req_type !== 5'h10) check(phase, pe.ph);
         end
         last_e = pe;
         have_last = 1'b1;
      end else if (have_last) begin
         check({err, word_lo, word_hi}, {last_e.err, last_e.lo, last_e.hi});
      end
      if (done === 1'b1 && done_cyc < 0) done_cyc = cyc;
      if (ser_valid === 1'b1) begin
         if (sq.size() == 0) first_cyc = cyc;
         sq.push_back(ser_bit);
         if (ser_last === 1'b1) last_idx = sq.size();
      end
      pend_v = v;
      pend_c = c;
      pe = ref_conv(a, t, f, c);
      cw_q = w;
      cw_in = w;
      host.put(v, a, t, f, c);
   endtask

   // one request streamed out; a second one while busy must be ignored
   task automatic ser_run(input logic [32:0] a, input logic busy);
      pacc_exp_t   e;
      logic [41:0] vec;
      int          n;
      repeat (50) step(1'b0, a, 5'h00, 7'h00, 3'h0, 21'h00_0000);
      sq.delete();
      done_cyc = -1;
      last_idx = -1;
      e = ref_conv(a, 5'h00, 7'h00, 3'h0);
      vec = {e.hi, e.lo};
      n = e.lng ? 42 : 21;
      step(1'b1, a, 5'h00, 7'h00, 3'h0, 21'h00_0000);
      for (int i = 0; i < 60; i++) begin
         step(busy && i == 5, SHORT_HI, 5'h00, 7'h00, 3'h0, 21'h00_0000);
      end
      check(sq.size(), n);
      check(first_cyc - done_cyc, 2);
      check(last_idx, n);
      for (int i = 0; i < n && i < sq.size(); i++) begin
         check(sq[i], vec[i]);
      end
   endtask

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      cw_in = 21'h00_0000;
      {err_total, check_count, cyc} = 0;
      {pend_v, have_last, pend_c, cw_q} = '0;
      void'($urandom(32'hE08C));
      bnd = '{33'h0_0000_0000, 33'h0_0000_0001, SHORT_HI, SHORT_HI + 1,
              ILL1_HI, RSV1_HI, RSV1_HI + 1, SPEC_HI, SPEC_HI + 1, RSV2_HI,
              ILL2_HI, ILL2_HI + 1, L12_HI, L12_HI + 1, L13_HI, L13_HI + 1,
              L14_HI, L14_HI + 1, L23_CTRY_HI, L23_CTRY_HI + 1, L23_RSV_HI,
              L23_RSV_HI + 1, L23_HI, L23_HI + 1, 33'h1_0020_0FFE,
              33'h1_FFFF_FFFF};
      cwb = '{CW_IDLE0, CW_IDLE0 + 1, CW_L1_HI, CW_L1_HI + 1, CW_S_HI,
              CW_S_HI + 1, CW_L3_HI, CW_L3_HI + 1, CW_L4_HI, CW_L4_HI + 1,
              CW_SS_HI, CW_SS_HI + 1, CW_IDLE1 - 1, CW_IDLE1};
      repeat (4) @(posedge clock);
      check(frame_step, 8'h01);
      check(cw_class, PACC_CW_IDLE);
      check({done, err, word_lo, word_hi, ser_valid}, 64'h0);
      #1;
      rst_n = 1'b1;
      // every boundary against every code type, back to back
      foreach (bnd[i]) begin
         for (int t = 0; t < 18; t++) begin
            step(1'b1, bnd[i], 5'(t), 7'($urandom), 3'(t), cwb[t % 14]);
         end
      end
      repeat (3000) begin
         step($urandom_range(0, 3) != 0,
              $urandom_range(0, 1) ? bnd[$urandom_range(0, 25)] +
                 33'($urandom_range(0, 40000)) - 33'h0_0000_4E20 :
                 {1'($urandom), 32'($urandom)},
              5'($urandom), 7'($urandom), 3'($urandom), 21'($urandom));
      end
      ser_run(33'($urandom_range(1, 1933312)), 1'b0);
      ser_run(ILL2_HI + 1, 1'b0);
      ser_run(L12_HI + 33'($urandom_range(1, 99999)), 1'b0);
      ser_run(L14_HI + 33'($urandom_range(1, 99999)), 1'b0);
      ser_run(L13_HI + 33'($urandom_range(1, 99999)), 1'b1);
      step(1'b0, 33'h0_0000_0000, 5'h00, 7'h00, 3'h0, 21'h00_0000);
      tally_and_finish();
   end

   // hang guard: well beyond the few thousand cycles expected
   initial begin
      #400000;
      err_total++;
      tally_and_finish();
   end
endmodule // pager_address_code_converter_test

`default_nettype wire
